// >>> logic/uart_dds.sv
/*
 * double buffered uart with phase accumulator baud tick, axi4-lite slave.
 * assumes a single 50 MHz clock, synchronous active high reset, and that
 * the serial input is already synchronous to clk_i.
 */
`default_nettype none
module uart_dds
   import uart_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [7:0]  s_axi_awaddr_i,
   input  wire logic        s_axi_awvalid_i,
   output logic             s_axi_awready_o,
   input  wire logic [31:0] s_axi_wdata_i,
   input  wire logic [3:0]  s_axi_wstrb_i,
   input  wire logic        s_axi_wvalid_i,
   output logic             s_axi_wready_o,
   output logic [1:0]       s_axi_bresp_o,
   output logic             s_axi_bvalid_o,
   input  wire logic        s_axi_bready_i,
   input  wire logic [7:0]  s_axi_araddr_i,
   input  wire logic        s_axi_arvalid_i,
   output logic             s_axi_arready_o,
   output logic [31:0]      s_axi_rdata_o,
   output logic [1:0]       s_axi_rresp_o,
   output logic             s_axi_rvalid_o,
   input  wire logic        s_axi_rready_i,
   input  wire logic        rx_i,
   output logic             tx_o
);
   // ***********************************
   // baud tick
   // ***********************************
   logic [ACC_W-1:0] acc_q;
   logic             msb_q;
   logic             tick;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         acc_q <= '0;
      end else begin
         acc_q <= acc_q + ACC_W'(PHASE_INC);
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         msb_q <= 1'b0;
      end else begin
         msb_q <= acc_q[ACC_W-1];
      end
   end
   // a tick is the rising edge of the accumulator msb, seen by the system clock
   assign tick = acc_q[ACC_W-1] & ~msb_q;
   // ***********************************
   // register bus
   // ***********************************
   logic       aw_q, w_q;
   logic [7:0] awaddr_q;
   logic [7:0] wdata_q;
   logic       wlane_q;
   logic       do_wr, wr_en, tx_push, rx_pop, loop_q;
   par_t       par;
   rx_err_t    err_q, err_set, err_clr;
   // write decode, shared by the data, status and control registers
   function automatic logic wr_hit(input logic en, input logic [7:0] addr,
                                   input logic [7:0] target);
      return en && addr == target;
   endfunction
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         aw_q     <= 1'b0;
         awaddr_q <= 8'h00;
      end else if (s_axi_awvalid_i && s_axi_awready_o) begin
         aw_q     <= 1'b1;
         awaddr_q <= s_axi_awaddr_i;
      end else if (do_wr) begin
         aw_q     <= 1'b0;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         w_q     <= 1'b0;
         wdata_q <= 8'h00;
         wlane_q <= 1'b0;
      end else if (s_axi_wvalid_i && s_axi_wready_o) begin
         w_q     <= 1'b1;
         wdata_q <= s_axi_wdata_i[7:0];
         wlane_q <= s_axi_wstrb_i[0];
      end else if (do_wr) begin
         w_q     <= 1'b0;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_axi_awready_o <= 1'b1;
         s_axi_wready_o  <= 1'b1;
      end else begin
         s_axi_awready_o <= !(aw_q || (s_axi_awvalid_i && s_axi_awready_o)) || do_wr;
         s_axi_wready_o  <= !(w_q || (s_axi_wvalid_i && s_axi_wready_o)) || do_wr;
      end
   end
   assign do_wr   = aw_q && w_q && !s_axi_bvalid_o;
   // a write with the low lane off completes on the bus but changes nothing
   assign wr_en   = do_wr && wlane_q;
   assign tx_push = wr_hit(wr_en, awaddr_q, ADDR_DATA);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o  <= RESP_OKAY;
      end else if (do_wr) begin
         s_axi_bvalid_o <= 1'b1;
         s_axi_bresp_o  <= (awaddr_q == ADDR_DATA || awaddr_q == ADDR_CTRL ||
                            awaddr_q == ADDR_STAT) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready_i) begin
         s_axi_bvalid_o <= 1'b0;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         loop_q <= 1'b0;
      end else if (wr_hit(wr_en, awaddr_q, ADDR_CTRL)) begin
         loop_q <= wdata_q[BIT_LOOP];
      end
   end
   // read path: one cycle from address to data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_axi_arready_o <= 1'b1;
      end else if (s_axi_arvalid_i && s_axi_arready_o) begin
         s_axi_arready_o <= 1'b0;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
         s_axi_arready_o <= 1'b1;
      end
   end
   assign rx_pop = s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == ADDR_DATA;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o  <= 32'h0000_0000;
         s_axi_rresp_o  <= RESP_OKAY;
      end else if (s_axi_arvalid_i && s_axi_arready_o) begin
         s_axi_rvalid_o <= 1'b1;
         s_axi_rresp_o  <= RESP_OKAY;
         case (s_axi_araddr_i)
            ADDR_DATA: s_axi_rdata_o <= {22'h0, par.tx_rdy, par.rx_rdy, par.data};
            ADDR_STAT: s_axi_rdata_o <= {29'h0, err_q};
            ADDR_CTRL: s_axi_rdata_o <= {31'h0, loop_q};
            default: begin
               s_axi_rdata_o <= 32'h0000_0000;
               s_axi_rresp_o <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready_i) begin
         s_axi_rvalid_o <= 1'b0;
      end
   end
   // ***********************************
   // transmitter
   // ***********************************
   tx_state_t          tx_st_q;
   logic [DATA_W-1:0]  hold_q;
   logic               pend_q;
   logic [DATA_W+STOP_BITS:0] sh_q;
   logic [CNT_W-1:0]   tx_tk_q;
   logic [3:0]         tx_bit_q;
   logic               tx_bit_end;
   assign tx_bit_end = tick && tx_tk_q == CNT_W'(OVERSAMPLE - 1);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hold_q <= '0;
         pend_q <= 1'b0;
      end else if (tx_push) begin
         hold_q <= wdata_q;
         pend_q <= 1'b1;
      end else if (tx_st_q == TX_LOAD) begin
         pend_q <= 1'b0;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_st_q  <= TX_IDLE;
         sh_q     <= '1;
         tx_tk_q  <= '0;
         tx_bit_q <= '0;
      end else begin
         case (tx_st_q)
            TX_IDLE: if (pend_q) tx_st_q <= TX_WAIT;
            TX_WAIT: if (tick) tx_st_q <= TX_LOAD;
            TX_LOAD: begin
               sh_q     <= {{STOP_BITS{1'b1}}, hold_q, 1'b0};
               tx_tk_q  <= '0;
               tx_bit_q <= '0;
               tx_st_q  <= TX_DATA;
            end
            TX_DATA: if (tick) begin
               tx_tk_q <= tx_tk_q + CNT_W'(1);
               if (tx_bit_end) begin
                  tx_tk_q  <= '0;
                  sh_q     <= {1'b1, sh_q[DATA_W+STOP_BITS:1]};
                  tx_bit_q <= tx_bit_q + 4'h1;
                  if (tx_bit_q == 4'(DATA_W + STOP_BITS)) begin
                     tx_st_q <= pend_q ? TX_LOAD : TX_IDLE;
                  end
               end
            end
            default: tx_st_q <= TX_IDLE;
         endcase
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_o <= 1'b1;
      end else begin
         // the line rests high outside the data state
         tx_o <= (tx_st_q == TX_DATA) ? sh_q[0] : 1'b1;
      end
   end
   // ***********************************
   // receiver
   // ***********************************
   rx_state_t          rx_st_q;
   logic               rx_line;
   logic [RX_BITS-1:0] rsh_q;
   logic [CNT_W-1:0]   rx_tk_q;
   logic [3:0]         rx_bit_q;
   logic [DATA_W-1:0]  rbuf_q;
   logic               rx_rdy_q;
   logic               tx_rdy_q;
   assign rx_line = loop_q ? tx_o : rx_i;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_st_q  <= RX_IDLE;
         rsh_q    <= '0;
         rx_tk_q  <= '0;
         rx_bit_q <= '0;
      end else begin
         case (rx_st_q)
            RX_IDLE: if (!rx_line) begin
               rx_st_q  <= RX_DATA;
               rx_tk_q  <= '0;
               rx_bit_q <= '0;
            end
            RX_DATA: if (tick) begin
               rx_tk_q <= rx_tk_q + CNT_W'(1);
               // first sample half a bit in, then every full bit
               if (rx_tk_q == CNT_W'(HALF_BIT - 1) + (rx_bit_q != 4'h0 ?
                   CNT_W'(HALF_BIT) : CNT_W'(0))) begin
                  rx_tk_q  <= '0;
                  rsh_q    <= {rx_line, rsh_q[RX_BITS-1:1]};
                  rx_bit_q <= rx_bit_q + 4'h1;
                  if (rx_bit_q == 4'(RX_BITS - 1)) rx_st_q <= RX_LOAD;
               end
            end
            RX_LOAD: rx_st_q <= rx_line ? RX_IDLE : RX_WAIT;
            RX_WAIT: if (rx_line) rx_st_q <= RX_IDLE;
            default: rx_st_q <= RX_IDLE;
         endcase
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rbuf_q <= '0;
      end else if (rx_st_q == RX_LOAD) begin
         rbuf_q <= rsh_q[DATA_W:1];
      end
   end
   // rx ready: a load outranks a pop, so a byte landing during a read stays flagged
   // tx ready: a push outranks a load, as the pushed byte is then still pending
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_rdy_q <= 1'b0;
      end else if (rx_st_q == RX_LOAD) begin
         rx_rdy_q <= 1'b1;
      end else if (rx_pop) begin
         rx_rdy_q <= 1'b0;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_rdy_q <= 1'b1;
      end else if (tx_push) begin
         tx_rdy_q <= 1'b0;
      end else if (tx_st_q == TX_LOAD) begin
         tx_rdy_q <= 1'b1;
      end
   end
   // ***********************************
   // error flags
   // ***********************************
   always_comb begin
      err_set = '0;
      err_clr = '0;
      if (rx_st_q == RX_LOAD) begin
         err_set.bad_start = rsh_q[0];
         err_set.bad_stop  = ~rsh_q[RX_BITS-1];
         err_set.overrun   = rx_rdy_q & ~rx_pop;
      end
      if (wr_hit(wr_en, awaddr_q, ADDR_STAT)) begin
         err_clr.bad_start = wdata_q[BIT_ERR_START];
         err_clr.bad_stop  = wdata_q[BIT_ERR_STOP];
         err_clr.overrun   = wdata_q[BIT_ERR_OVR];
      end
   end
   // an event in the cycle of a write-one clear still sets its flag
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         err_q <= '0;
      end else begin
         err_q <= (err_q & ~err_clr) | err_set;
      end
   end
   assign par = '{data: rbuf_q, rx_rdy: rx_rdy_q, tx_rdy: tx_rdy_q};
endmodule
`default_nettype wire

// >>> logic/uart_pkg.sv
/*
 * package for the double buffered uart: register map, field layout,
 * build constants, state encodings and carrier structs.
 * assumes a 50 MHz system clock and an axi4-lite register bus.
 */
`default_nettype none
package uart_pkg;
   // ***********************************
   // clock and line figures
   // ***********************************
   localparam int unsigned CLK_HZ      = 50_000_000;
   localparam int unsigned BAUD_HZ     = 115_200;
   localparam int unsigned OVERSAMPLE  = 16;
   localparam int unsigned DATA_W      = 8;
   localparam int unsigned STOP_BITS   = 1;
   localparam int unsigned INC_W       = 8;
   // tick rate and accumulator width derived so the increment sits in [0.5:1.0) of 2^INC_W
   localparam longint unsigned TICK_HZ = longint'(BAUD_HZ) * OVERSAMPLE;
   function automatic int acc_width();
      int d;
      longint unsigned inc;
      d = INC_W;
      inc = 0;
      for (int k = INC_W; k < 40; k++) begin
         inc = (TICK_HZ * (64'h1 << k) + CLK_HZ / 2) / CLK_HZ;
         if (inc < (64'h1 << INC_W)) begin
            d = k;
         end
      end
      return d;
   endfunction
   localparam int unsigned ACC_W = acc_width();
   localparam logic [INC_W-1:0] PHASE_INC =
      INC_W'((TICK_HZ * (64'h1 << ACC_W) + CLK_HZ / 2) / CLK_HZ);
   localparam int unsigned HALF_BIT = OVERSAMPLE / 2;
   localparam int unsigned CNT_W    = 8;
   localparam int unsigned RX_BITS  = DATA_W + 2;
   // ***********************************
   // register map (byte addresses)
   // ***********************************
   localparam logic [7:0]  ADDR_DATA   = 8'h00;
   localparam logic [7:0]  ADDR_STAT   = 8'h04;
   localparam logic [7:0]  ADDR_CTRL   = 8'h08;
   localparam int unsigned BIT_RX_RDY  = 8;
   localparam int unsigned BIT_TX_RDY  = 9;
   localparam int unsigned BIT_LOOP    = 0;
   localparam int unsigned BIT_ERR_START = 0;
   localparam int unsigned BIT_ERR_STOP  = 1;
   localparam int unsigned BIT_ERR_OVR   = 2;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   // ***********************************
   // states (gray along usual tx path; rx load back to idle flips both bits)
   // ***********************************
   typedef enum logic [1:0] {
      TX_IDLE = 2'h0, TX_WAIT = 2'h1, TX_LOAD = 2'h3, TX_DATA = 2'h2
   } tx_state_t;
   typedef enum logic [1:0] {
      RX_IDLE = 2'h0, RX_DATA = 2'h1, RX_LOAD = 2'h3, RX_WAIT = 2'h2
   } rx_state_t;
   // ***********************************
   // carriers
   // ***********************************
   typedef struct packed {
      logic        overrun;
      logic        bad_stop;
      logic        bad_start;
   } rx_err_t;
   typedef struct packed {
      logic [7:0]  data;
      logic        rx_rdy;
      logic        tx_rdy;
   } par_t;
endpackage
`default_nettype wire

// >>> test/uart_dds_sva.sv
/* checker for uart_dds: bus handshakes, reset state and line shape.
   assumes one clock and a synchronous active high reset. */
`default_nettype none
module uart_dds_sva
   import uart_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        s_axi_awvalid_i,
   input wire logic        s_axi_awready_o,
   input wire logic        s_axi_wvalid_i,
   input wire logic        s_axi_wready_o,
   input wire logic [1:0]  s_axi_bresp_o,
   input wire logic        s_axi_bvalid_o,
   input wire logic        s_axi_bready_i,
   input wire logic [7:0]  s_axi_araddr_i,
   input wire logic        s_axi_arvalid_i,
   input wire logic        s_axi_arready_o,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic [1:0]  s_axi_rresp_o,
   input wire logic        s_axi_rvalid_o,
   input wire logic        s_axi_rready_i,
   input wire logic        tx_o
);
   // ********************
   // properties
   // ********************
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_RESET_STATE: assert property ($fell(rst_i) |-> tx_o && s_axi_awready_o
      && !s_axi_bvalid_o && !s_axi_rvalid_o) else $error("bad state after reset");
   AST_B_LATENCY: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
      && s_axi_wready_o |-> ##2 s_axi_bvalid_o) else $error("write answer late");
   AST_B_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
      s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write answer dropped");
   AST_R_NEXT: assert property (s_axi_arvalid_i && s_axi_arready_o |=>
      s_axi_rvalid_o) else $error("read answer late");
   AST_R_HOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
      s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read answer dropped");
   AST_R_TOP: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:10] == '0)
      else $error("upper read bits set");
   AST_UNMAPPED: assert property (s_axi_arvalid_i && s_axi_arready_o
      && s_axi_araddr_i > ADDR_CTRL |=> s_axi_rresp_o == RESP_SLVERR && s_axi_rdata_o == '0)
      else $error("unmapped read not refused");
   AST_START_BIT: assert property ($fell(tx_o) |=> !tx_o [*8])
      else $error("start bit too short");
endmodule
bind uart_dds uart_dds_sva chk_u (.clk_i(clk_i), .rst_i(rst_i),
   .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
   .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
   .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
   .s_axi_bready_i(s_axi_bready_i), .s_axi_araddr_i(s_axi_araddr_i),
   .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
   .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
   .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i), .tx_o(tx_o));
`default_nettype wire

// >>> test/serial_peer.sv
/* serial peer at ttl levels: sends frames to the receiver, collects
   frames from the transmitter. assumes 115200 baud on a 50 MHz clock. */
`default_nettype none
module serial_peer #(
   parameter int BIT_CYC = 434
) (
   input  wire logic clk_i,
   input  wire logic tx_i,
   output var  logic rx_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ********************
   // send and collect
   // ********************
   logic [8:0] got_q[$];
   logic [7:0] sh;
   initial rx_o = 1'b1;
   task automatic send(input logic [7:0] b, input bit bad_stop, input bit bad_start);
      logic [9:0] f;
      f = {~bad_stop, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge clk_i) rx_o <= f[i];
         repeat (bad_start ? BIT_CYC / 4 : BIT_CYC - 1) @(posedge clk_i);
         if (bad_start) break;
      end
      @(posedge clk_i) rx_o <= 1'b1;
   endtask
   always begin
      @(negedge tx_i);
      repeat (BIT_CYC / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CYC) @(posedge clk_i);
         sh[i] = tx_i;
      end
      repeat (BIT_CYC) @(posedge clk_i);
      got_q.push_back({tx_i, sh});
   end
endmodule
`default_nettype wire

// >>> test/double_buffered_uart_dds_baud_bench.sv
/* self-checking bench for uart_dds over axi4-lite with a serial peer.
   assumes the uart_pkg register map and a 50 MHz clock. */
`default_nettype none
module double_buffered_uart_dds_baud_bench
   import uart_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00, b, b2;
   logic [31:0] wdata = 32'h0, v, rdata;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, tx, rx;
   logic [1:0]  bresp, rresp;
   logic [8:0]  got;
   logic [7:0]  exp_q[$];
   int          n_fail = 0, samples_checked = 0, cyc = 0;
   integer      seed = 32'hF7707CF8;
   always #10 clk_i = ~clk_i;
   uart_dds dut_u (.clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr),
      .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready), .rx_i(rx), .tx_o(tx));
   serial_peer peer_u (.clk_i(clk_i), .tx_i(tx), .rx_o(rx));
   // ********************
   // tasks
   // ********************
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         n_fail++;
         wrap_up();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge clk_i);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid && !bready) bready <= 1'b1;
      end while (!(bvalid && bready));
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, RESP_OKAY});
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk_i);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge clk_i);
         if (arready) arvalid <= 1'b0;
         if (rvalid && !rready) rready <= 1'b1;
      end while (!(rvalid && rready));
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   task automatic rdx(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      chk(d & m, e);
      chk({30'h0, r}, {30'h0, er});
   endtask
   task automatic poll(input int n, output logic [31:0] d);
      logic [1:0] r;
      do rd(ADDR_DATA, d, r);
      while (d[n] !== 1'b1);
   endtask
   task automatic txcheck();
      while (exp_q.size() > 0) begin
         while (peer_u.got_q.size() == 0) @(posedge clk_i);
         got = peer_u.got_q.pop_front();
         chk({23'h0, got}, {24'h1, exp_q.pop_front()});
      end
   endtask
   // ********************
   // scenarios
   // ********************
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      rdx(ADDR_DATA, 32'h300, 32'h200, RESP_OKAY);
      rdx(ADDR_STAT, 32'h7, 32'h0, RESP_OKAY);
      rdx(8'h0C, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
      b = 8'($random(seed));
      b2 = 8'($random(seed));
      wr(ADDR_DATA, {24'h0, b});
      exp_q.push_back(b);
      poll(BIT_TX_RDY, v);
      wr(ADDR_DATA, {24'h0, b2});
      exp_q.push_back(b2);
      rdx(ADDR_DATA, 32'h200, 32'h0, RESP_OKAY);
      poll(BIT_TX_RDY, v);
      txcheck();
      b = 8'($random(seed));
      peer_u.send(b, 1'b0, 1'b0);
      poll(BIT_RX_RDY, v);
      chk(v & 32'hFF, {24'h0, b});
      rdx(ADDR_DATA, 32'h1FF, {24'h0, b}, RESP_OKAY);
      b2 = 8'($random(seed));
      peer_u.send(b, 1'b0, 1'b0);
      peer_u.send(b2, 1'b0, 1'b0);
      rdx(ADDR_STAT, 32'h7, 32'h4, RESP_OKAY);
      rdx(ADDR_DATA, 32'h1FF, {24'h1, b2}, RESP_OKAY);
      wr(ADDR_STAT, 32'h7);
      rdx(ADDR_STAT, 32'h7, 32'h0, RESP_OKAY);
      peer_u.send(b, 1'b1, 1'b0);
      rdx(ADDR_STAT, 32'h2, 32'h2, RESP_OKAY);
      rdx(ADDR_DATA, 32'h1FF, {24'h1, b}, RESP_OKAY);
      wr(ADDR_STAT, 32'h7);
      peer_u.send(b, 1'b0, 1'b1);
      repeat (5000) @(posedge clk_i);
      rdx(ADDR_STAT, 32'h1, 32'h1, RESP_OKAY);
      wr(ADDR_STAT, 32'h7);
      rdx(ADDR_DATA, 32'h1FF, 32'h1FF, RESP_OKAY);
      wr(ADDR_CTRL, 32'h1);
      b = 8'($random(seed));
      wr(ADDR_DATA, {24'h0, b});
      exp_q.push_back(b);
      poll(BIT_RX_RDY, v);
      chk(v & 32'hFF, {24'h0, b});
      txcheck();
      wr(ADDR_CTRL, 32'h0);
      wrap_up();
   end
endmodule
`default_nettype wire
